// ===== include/serial_regs_pkg.sv
// Constants and a carrier type for the synthesizer serial control port
package serial_regs_pkg;

    // ==========================================
    // Frame layout
    localparam int unsigned FRAME_BITS    = 32;
    localparam int unsigned DATA_BITS     = 24;
    localparam int unsigned ADDR_BITS     = 5;
    localparam int unsigned CHIP_BITS     = 3;
    localparam int unsigned CNT_BITS      = 6;
    localparam logic [2:0]  OWN_CHIP_ADDR = 3'h0;

    // ==========================================
    // Register offsets
    localparam logic [4:0] REG_IDENTITY = 5'h00;
    localparam logic [4:0] REG_ENABLE   = 5'h01;
    localparam logic [4:0] REG_REFERENCE_DIVIDER   = 5'h02;
    localparam logic [4:0] REG_INTDIV   = 5'h03;

    // ==========================================
    // Reset values and field positions
    localparam logic [23:0] ENABLE_RESET = 24'h00_0003;
    localparam logic [23:0] REFERENCE_DIVIDER_RESET = 24'h00_0001;
    localparam logic [23:0] INTDIV_RESET = 24'h00_0019;
    localparam int unsigned SOFT_RST_BIT = 5;
    localparam int unsigned PIN_SEL_BIT  = 0;
    localparam int unsigned SW_EN_BIT    = 1;
    localparam int unsigned KEEP_LO_BIT  = 2;
    localparam int unsigned KEEP_COUNT   = 6;
    localparam int unsigned REFERENCE_DIVIDER_W     = 14;
    localparam int unsigned INTDIV_W     = 19;

    // ==========================================
    // State carrier
    typedef struct packed {
        logic [2:0]  sclk_sync;
        logic [2:0]  latch_sync;
        logic [1:0]  sdi_sync;
        logic [31:0] shift_in;
        logic [23:0] shift_out;
        logic [5:0]  bit_cnt;
        logic [4:0]  read_addr;
        logic        readback_active;
        logic        driver_on;
        logic        pin_out;
        logic [23:0] enable_reg;
        logic [23:0] reference_divider_reg;
        logic [23:0] intdiv_reg;
    } port_state_s;

endpackage

// ===== logic/pll_serial_readback_regs.sv
// Serial control port with two-cycle register readback and control registers
`timescale 1ns/10ps
module pll_serial_readback_regs #(
    parameter logic [23:0] IDENTITY_VALUE = 24'h00_A5A5 // Arbitrary value
) (
    // Clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     sys_rst_i,
    // Serial pins
    input  wire logic                     shift_clock_i,
    input  wire logic                     serial_input_line_i,
    input  wire logic                     frame_latch_strobe_i,
    output logic                          lock_or_readback_pin_o,
    output logic                          lock_or_readback_pin_oe_o,
    // Analog side
    input  wire logic                     lock_detect_i,
    input  wire logic                     chip_enable_pin_i,
    output logic                          powered_up_o,
    output logic [serial_regs_pkg::KEEP_COUNT-1:0] keep_on_o,
    output logic [serial_regs_pkg::REFERENCE_DIVIDER_W-1:0]   reference_divider_o,
    output logic [serial_regs_pkg::INTDIV_W-1:0]   intdiv_o
);

    serial_regs_pkg::port_state_s s_q;
    serial_regs_pkg::port_state_s s_d;

    logic        sclk_rise;
    logic        latch_rise;
    logic [31:0] frame;
    logic [23:0] read_word;

    assign sclk_rise  = s_q.sclk_sync[1] & ~s_q.sclk_sync[2];
    assign latch_rise = s_q.latch_sync[1] & ~s_q.latch_sync[2];
    assign frame      = s_q.shift_in;

    // ==========================================
    // Read mux
    always_comb begin
        case (s_q.read_addr)
            serial_regs_pkg::REG_IDENTITY: read_word = IDENTITY_VALUE;
            serial_regs_pkg::REG_ENABLE:   read_word = s_q.enable_reg;
            serial_regs_pkg::REG_REFERENCE_DIVIDER:   read_word = s_q.reference_divider_reg;
            serial_regs_pkg::REG_INTDIV:   read_word = s_q.intdiv_reg;
            default:                       read_word = 24'h00_0000;
        endcase
    end

    // ==========================================
    // Next state
    always_comb begin
        s_d = s_q;
        // Pins are asynchronous to clock_i; only stage two onward is read
        s_d.sclk_sync  = {s_q.sclk_sync[1:0], shift_clock_i};
        s_d.latch_sync = {s_q.latch_sync[1:0], frame_latch_strobe_i};
        s_d.sdi_sync   = {s_q.sdi_sync[0], serial_input_line_i};

        if (sclk_rise) begin
            s_d.shift_in = {s_q.shift_in[30:0], s_q.sdi_sync[1]};
            // First edge of a cycle loads the word, later ones walk it out
            if (s_q.bit_cnt == 6'h00) begin
                s_d.shift_out       = {read_word[22:0], 1'b0};
                s_d.pin_out         = read_word[serial_regs_pkg::DATA_BITS-1];
                s_d.readback_active = 1'b1;
            end else begin
                s_d.shift_out = {s_q.shift_out[22:0], 1'b0};
                s_d.pin_out   = s_q.shift_out[serial_regs_pkg::DATA_BITS-1];
            end
            if (s_q.bit_cnt != 6'(serial_regs_pkg::FRAME_BITS))
                s_d.bit_cnt = s_q.bit_cnt + 6'h01;
        end

        if (latch_rise) begin
            s_d.bit_cnt         = 6'h00;
            s_d.readback_active = 1'b0;
            s_d.driver_on = (frame[serial_regs_pkg::CHIP_BITS-1:0]
                             == serial_regs_pkg::OWN_CHIP_ADDR);
            if (frame[serial_regs_pkg::CHIP_BITS-1:0] == serial_regs_pkg::OWN_CHIP_ADDR) begin
                case (frame[7:3])
                    serial_regs_pkg::REG_IDENTITY: begin
                        // Data field starts above the register and chip address
                        s_d.read_addr = frame[8 +: serial_regs_pkg::ADDR_BITS];
                        if (frame[8 + serial_regs_pkg::SOFT_RST_BIT]) begin
                            s_d.enable_reg = serial_regs_pkg::ENABLE_RESET;
                            s_d.reference_divider_reg = serial_regs_pkg::REFERENCE_DIVIDER_RESET;
                            s_d.intdiv_reg = serial_regs_pkg::INTDIV_RESET;
                        end
                    end
                    serial_regs_pkg::REG_ENABLE: s_d.enable_reg = frame[31:8];
                    serial_regs_pkg::REG_REFERENCE_DIVIDER: s_d.reference_divider_reg = frame[31:8];
                    serial_regs_pkg::REG_INTDIV: s_d.intdiv_reg = frame[31:8];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q            <= '0;
            s_q.enable_reg <= serial_regs_pkg::ENABLE_RESET;
            s_q.reference_divider_reg <= serial_regs_pkg::REFERENCE_DIVIDER_RESET;
            s_q.intdiv_reg <= serial_regs_pkg::INTDIV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs
    logic cen_q1;
    logic cen_q2;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cen_q1 <= 1'b0;
            cen_q2 <= 1'b0;
        end else begin
            cen_q1 <= chip_enable_pin_i;
            cen_q2 <= cen_q1;
        end
    end

    // Lock detect is a same-domain analog-side level; readback hides it
    assign lock_or_readback_pin_o    = s_q.readback_active ? s_q.pin_out
                                                            : lock_detect_i;
    assign lock_or_readback_pin_oe_o = s_q.driver_on | s_q.readback_active
                                       | s_q.enable_reg[7];
    assign powered_up_o = s_q.enable_reg[serial_regs_pkg::PIN_SEL_BIT] ? cen_q2
                        : s_q.enable_reg[serial_regs_pkg::SW_EN_BIT];
    assign keep_on_o = s_q.enable_reg[serial_regs_pkg::KEEP_LO_BIT +: serial_regs_pkg::KEEP_COUNT];
    assign reference_divider_o  = s_q.reference_divider_reg[serial_regs_pkg::REFERENCE_DIVIDER_W-1:0];
    assign intdiv_o  = s_q.intdiv_reg[serial_regs_pkg::INTDIV_W-1:0];

endmodule

// ===== tb/port_checker.sv
// Concurrent checks on the serial control port pins
`timescale 1ns/10ps
module port_checker (
    input wire logic        clock_i, sys_rst_i, shift_clock_i,
    input wire logic        frame_latch_strobe_i, lock_detect_i,
    input wire logic        chip_enable_pin_i, powered_up_o,
    input wire logic        lock_or_readback_pin_o, lock_or_readback_pin_oe_o,
    input wire logic [5:0]  keep_on_o,
    input wire logic [13:0] reference_divider_o,
    input wire logic [18:0] intdiv_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Pins quiet long enough for the synchronisers to settle
    sequence quiet;
        ($stable(shift_clock_i) && $stable(frame_latch_strobe_i) && $stable(lock_detect_i))[*8];
    endsequence
    chk_reset_defaults: assert property ($fell(sys_rst_i) |-> reference_divider_o == 14'h0001
        && intdiv_o == 19'h0_0019 && keep_on_o == 6'h00) else $error("bad defaults");
    chk_reference_divider_commit: assert property ($changed(reference_divider_o) |-> frame_latch_strobe_i)
        else $error("reference_divider moved");
    chk_intdiv_commit: assert property (intdiv_o != $past(intdiv_o) |-> frame_latch_strobe_i)
        else $error("intdiv moved");
    chk_keep_commit: assert property (!frame_latch_strobe_i |=> $stable(keep_on_o))
        else $error("keep moved");
    chk_pin_lock: assert property (frame_latch_strobe_i[*8] |->
        lock_or_readback_pin_o == lock_detect_i) else $error("pin not lock");
    chk_pin_holds: assert property (quiet |-> $stable(lock_or_readback_pin_o))
        else $error("pin moved");
    chk_oe_readback: assert property (lock_or_readback_pin_o != lock_detect_i |->
        lock_or_readback_pin_oe_o) else $error("oe low");
    chk_power_steady: assert property (($stable(chip_enable_pin_i) &&
        !frame_latch_strobe_i)[*8] |=> $stable(powered_up_o)) else $error("power moved");
endmodule
bind pll_serial_readback_regs port_checker checker_inst (.clock_i, .sys_rst_i, .shift_clock_i,
    .frame_latch_strobe_i, .lock_detect_i, .chip_enable_pin_i, .powered_up_o,
    .lock_or_readback_pin_o, .lock_or_readback_pin_oe_o, .keep_on_o, .reference_divider_o, .intdiv_o);

// ===== tb/serial_host_model.sv
// Host driving the three-wire serial port at an 80 ns bit period
`timescale 1ns/10ps
module serial_host_model (
    output logic      shift_clock_o,
    output logic      serial_input_line_o,
    output logic      frame_latch_strobe_o,
    input  wire logic readback_pin_i
);
    initial begin
        shift_clock_o = 1'b0;
        serial_input_line_o = 1'b0;
        frame_latch_strobe_o = 1'b0;
    end
    // Read bit sampled 35 ns after the rise, just before the falling edge
    task automatic xfer(input logic [31:0] w, output logic [23:0] rd);
        rd = '0;
        for (int i = 0; i < 32; i++) begin
            serial_input_line_o = w[31-i];
            #40 shift_clock_o = 1'b1;
            #35 if (i < 24) rd[23-i] = readback_pin_i;
            #5 shift_clock_o = 1'b0;
        end
        serial_input_line_o = ~w[0];
        #40 frame_latch_strobe_o = 1'b1;
        #160 frame_latch_strobe_o = 1'b0;
        #40;
    endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the serial control port
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t %h vs %h", $time, a, b); end end
module testbench;
    typedef struct packed {
        logic [4:0]  a;
        logic [23:0] d;
        logic [23:0] want;
    } row_s;
    localparam logic [23:0] ID = 24'h3C_96E1; // Arbitrary value
    logic        clock_i, sys_rst_i, lock_detect_i, chip_enable_pin_i;
    logic        sck, serial_input_line, frame_latch_strobe, pin, oe, pwr;
    logic [5:0]  keep;
    logic [13:0] rdiv;
    logic [18:0] idiv;
    logic [23:0] rd;
    int          bad_count = 0, total_checks = 0, cycles = 0;
    row_s        rows [4] = '{'{5'h02, 24'hFF_FFFF, 24'hFF_FFFF},
        '{5'h03, 24'h07_FFFF, 24'h07_FFFF}, '{5'h01, 24'h00_00FC, 24'h00_00FC},
        '{5'h00, 24'h00_0000, ID}};
    pll_serial_readback_regs #(.IDENTITY_VALUE(ID)) DUT (.clock_i, .sys_rst_i,
        .shift_clock_i(sck), .serial_input_line_i(serial_input_line), .frame_latch_strobe_i(frame_latch_strobe),
        .lock_or_readback_pin_o(pin), .lock_or_readback_pin_oe_o(oe), .lock_detect_i,
        .chip_enable_pin_i, .powered_up_o(pwr), .keep_on_o(keep), .reference_divider_o(rdiv),
        .intdiv_o(idiv));
    serial_host_model host (.shift_clock_o(sck), .serial_input_line_o(serial_input_line),
        .frame_latch_strobe_o(frame_latch_strobe), .readback_pin_i(pin));
    task automatic frame(input logic [4:0] a, input logic [23:0] d, input logic [2:0] c);
        @(posedge clock_i) #1;
        host.xfer({d, a, c}, rd);
    endtask
    task automatic stop_test;
        $display("checks %0d bad %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 10000) begin
            bad_count++;
            stop_test;
        end
    end
    initial begin
        sys_rst_i = 1'b1;
        lock_detect_i = 1'b0;
        chip_enable_pin_i = 1'b1;
        repeat (8) @(posedge clock_i);
        #1 sys_rst_i = 1'b0;
        repeat (4) @(posedge clock_i);
        #1 `CHK({rdiv, idiv, pwr, keep, oe}, {14'h0001, 19'h0_0019, 8'h80})
        #1 chip_enable_pin_i = 1'b0;
        repeat (6) @(posedge clock_i);
        `CHK(pwr, 1'b0)
        #1 chip_enable_pin_i = 1'b1;
        frame(5'h02, 24'h00_0005, 3'h1);
        `CHK(rdiv, 14'h0001)
        `CHK(oe, 1'b0)
        $display("reset and refusal done");
        for (int i = 0; i < 4; i++) begin
            frame(rows[i].a, rows[i].d, 3'h0);
            frame(5'h00, {19'h0, rows[i].a}, 3'h0);
            frame(5'h00, {19'h0, rows[i].a}, 3'h0);
            `CHK(rd, rows[i].want)
        end
        `CHK({rdiv, idiv, keep, pwr}, {14'h3FFF, 19'h7_FFFF, 6'h3F, 1'b0})
        @(posedge clock_i) #1 lock_detect_i = 1'b1;
        #1 `CHK({pin, oe}, 2'b11)
        $display("rows done");
        frame(5'h00, 24'h00_0020, 3'h0);
        `CHK({rdiv, idiv, keep, pwr}, {14'h0001, 19'h0_0019, 7'h01})
        $display("soft reset done");
        stop_test;
    end
endmodule
